/* hdl/dac_top.sv */
/*
 * DRAM access timing control: Avalon-MM register slave plus the access
 * sequencer whose phase lengths the register fields select.
 * Assumes the bus controller issues access requests on the same clock and
 * supplies its own idle condition and idle length.
 */
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module dac_top
  import dac_pkg::*;
#(
  parameter int AW = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [AW-1:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Access request from bus controller
  input  wire logic        acc_req,
  output logic             acc_ready,
  input  wire logic        acc_sdram,
  input  wire logic        acc_write,
  input  wire logic        acc_dma_single,
  input  wire logic        acc_refresh,
  input  wire logic        acc_back_to_back,
  input  wire logic        acc_next_normal,
  input  wire logic        clat_state_en,
  input  wire logic        idle_cond_met,
  input  wire logic [2:0]  idle_len_states,
  // Access phases
  output logic             ph_ras,
  output logic             ph_rcd_wait,
  output logic             ph_clat,
  output logic             ph_cas,
  output logic             ph_suspend,
  output logic             ph_precharge,
  output logic             ph_idle_ins,
  output logic             acc_done
);

  // Address width must cover the map and fit the byte offset
  if (AW < 3 || AW > 8) begin : g_aw_check
    $error("dac_top: AW must be 3..8");
  end

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [15:0] ctl;
    logic        ack;
    logic [15:0] rdata;
    dac_state_t  st;
    logic [2:0]  cnt;
    logic        done;
    logic        sdram;
    logic        write;
    logic        dma;
    logic        refresh;
    logic        b2b;
    logic        nnorm;
    logic        clat_en;
    logic        icond;
    logic [2:0]  ilen;
  } dac_regs_t;

  dac_regs_t r_q;
  dac_regs_t r_d;
  dac_cfg_if cfg ();

  assign cfg.ctl = r_q.ctl;

  // Field decoder
  dac_field_dec u_dec (
    .cfg (cfg.dec)
  );

  // Bus and phase outputs
  assign avs_waitrequest = (avs_read | avs_write) & ~r_q.ack;
  assign avs_readdata    = {16'h0000, r_q.rdata};
  assign acc_ready       = r_q.st == DAC_S_IDLE;
  assign ph_ras          = r_q.st == DAC_S_RAS;
  assign ph_rcd_wait     = r_q.st == DAC_S_RCD;
  assign ph_clat         = r_q.st == DAC_S_CLAT;
  assign ph_cas          = r_q.st == DAC_S_CAS;
  assign ph_suspend      = r_q.st == DAC_S_SUSP;
  assign ph_precharge    = r_q.st == DAC_S_PRE;
  assign ph_idle_ins     = r_q.st == DAC_S_INS;
  assign acc_done        = r_q.done;

  // ***************************************************
  // Next state
  // ***************************************************
  logic hit;
  logic clat_need;
  logic susp_need;
  logic ins_need;

  always_comb begin
    r_d  = r_q;
    hit  = avs_address == DAC_OFS_CTL[AW-1:0];
    r_d.done = 1'b0;
    // Latency state unless dropped in SDRAM write bursts
    clat_need = r_q.sdram & r_q.clat_en & ~(r_q.write & r_q.b2b & cfg.wcl_dis);
    susp_need = r_q.sdram & ~r_q.write & r_q.dma & cfg.cksp_en;
    // Idle gating from the enable field and the bus controller's own settings
    ins_need  = ~r_q.refresh & cfg.idle_en & r_q.nnorm & r_q.icond
                & (r_q.ilen != 3'h0);
    // Bus slave, one wait cycle per access
    r_d.ack = (avs_read | avs_write) & ~r_q.ack;
    if (avs_read && !r_q.ack) begin
      r_d.rdata = hit ? r_q.ctl : 16'h0000;
    end
    if (avs_write && r_q.ack && hit) begin
      if (avs_byteenable[0]) r_d.ctl[7:0]  = avs_writedata[7:0];
      if (avs_byteenable[1]) r_d.ctl[15:8] = avs_writedata[15:8];
    end
    // Access sequencer
    case (r_q.st)
      DAC_S_IDLE: begin
        if (acc_req) begin
          r_d.sdram   = acc_sdram;
          r_d.write   = acc_write;
          r_d.dma     = acc_dma_single;
          r_d.refresh = acc_refresh;
          r_d.b2b     = acc_back_to_back;
          r_d.nnorm   = acc_next_normal;
          r_d.clat_en = clat_state_en;
          r_d.icond   = idle_cond_met;
          r_d.ilen    = idle_len_states;
          if (acc_refresh) begin
            r_d.st  = DAC_S_PRE;
            r_d.cnt = cfg.pre_states - 3'h1;
          end else begin
            r_d.st = DAC_S_RAS;
          end
        end
      end
      DAC_S_RAS: begin
        if (cfg.rcd_waits != 3'h0) begin
          r_d.st  = DAC_S_RCD;
          r_d.cnt = cfg.rcd_waits - 3'h1;
        end else begin
          r_d.st = clat_need ? DAC_S_CLAT : DAC_S_CAS;
        end
      end
      DAC_S_RCD: begin
        if (r_q.cnt == 3'h0) begin
          r_d.st = clat_need ? DAC_S_CLAT : DAC_S_CAS;
        end else begin
          r_d.cnt = r_q.cnt - 3'h1;
        end
      end
      DAC_S_CLAT: begin
        r_d.st = DAC_S_CAS;
      end
      DAC_S_CAS: begin
        if (susp_need) begin
          r_d.st  = DAC_S_SUSP;
          r_d.cnt = cfg.rdx_states - 3'h1;
        end else begin
          r_d.st  = DAC_S_PRE;
          r_d.cnt = cfg.pre_states - 3'h1;
        end
      end
      DAC_S_SUSP: begin
        if (r_q.cnt == 3'h0) begin
          r_d.st  = DAC_S_PRE;
          r_d.cnt = cfg.pre_states - 3'h1;
        end else begin
          r_d.cnt = r_q.cnt - 3'h1;
        end
      end
      DAC_S_PRE: begin
        if (r_q.cnt != 3'h0) begin
          r_d.cnt = r_q.cnt - 3'h1;
        end else if (ins_need) begin
          r_d.st  = DAC_S_INS;
          r_d.cnt = r_q.ilen - 3'h1;
        end else begin
          r_d.st   = DAC_S_IDLE;
          r_d.done = 1'b1;
        end
      end
      DAC_S_INS: begin
        if (r_q.cnt == 3'h0) begin
          r_d.st   = DAC_S_IDLE;
          r_d.done = 1'b1;
        end else begin
          r_d.cnt = r_q.cnt - 3'h1;
        end
      end
      default: begin
        r_d.st = DAC_S_IDLE;
      end
    endcase
  end

  // Register everything, fields cleared at reset except the state, which loads DAC_S_IDLE
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q     <= '0;
      r_q.ctl <= DAC_CTL_RESET;
      r_q.st  <= DAC_S_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  // ***************************************************
  // Checking helpers: cycles spent in the current state
  // ***************************************************
  logic [3:0] run_q;
  logic       leave;

  assign leave = r_d.st != r_q.st;

  // Run length counter
  always_ff @(posedge clk) begin
    if (sys_rst || leave) begin
      run_q <= 4'h1;
    end else if (run_q != 4'hF) begin
      run_q <= run_q + 4'h1;
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  AST_IDLE_ONLY_WHEN_ENABLED: assert property (@(posedge clk) disable iff (sys_rst)
    ph_idle_ins |-> r_q.ctl[DAC_B_IDLE] && r_q.nnorm && !r_q.refresh)
    else $error("idle inserted without enable");
  AST_IDLE_FOLLOWS_PRECHARGE: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_precharge && r_q.cnt == 3'h0 && r_q.ctl[DAC_B_IDLE] && r_q.nnorm && r_q.icond
     && !r_q.refresh && r_q.ilen != 3'h0) |=> ph_idle_ins)
    else $error("idle cycle missing");
  AST_IDLE_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_idle_ins && leave) |-> run_q == {1'b0, r_q.ilen} && r_q.icond)
    else $error("idle length wrong");
  AST_PRECHARGE_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_precharge && leave) |-> run_q == {2'b00, r_q.ctl[DAC_B_PRE +: 2]} + 4'h1)
    else $error("precharge length wrong");
  AST_CLAT_DROPPED: assert property (@(posedge clk) disable iff (sys_rst)
    ph_clat |-> r_q.clat_en && !(r_q.write && r_q.b2b && r_q.ctl[DAC_B_WCLD]))
    else $error("latency state not dropped");
  AST_RCD_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(ph_ras) |-> (ph_rcd_wait [*1] ##0 (r_q.ctl[DAC_B_RCD +: 2] != 2'b00))
                      or (!ph_rcd_wait && r_q.ctl[DAC_B_RCD +: 2] == 2'b00))
    else $error("RAS-to-CAS wait presence wrong");
  AST_RCD_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_rcd_wait && leave) |-> run_q == {2'b00, r_q.ctl[DAC_B_RCD +: 2]} ##1 (ph_cas || ph_clat))
    else $error("RAS-to-CAS wait count wrong");
  AST_SUSPEND_GATED: assert property (@(posedge clk) disable iff (sys_rst)
    ph_suspend |-> r_q.ctl[DAC_B_CKSP] && r_q.dma && r_q.sdram && !r_q.write)
    else $error("suspend without enable");
  AST_SUSPEND_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_suspend && leave) |-> run_q == {2'b00, r_q.ctl[DAC_B_RDX +: 2]} + 4'h1 ##1 ph_precharge)
    else $error("read extension length wrong");
  AST_RESET_CLEAR: assert property (@(posedge clk)
    $past(sys_rst) |-> r_q.ctl == 16'h0000 && acc_ready && !acc_done)
    else $error("fields not cleared by reset");

endmodule : dac_top

/* pkg/dac_pkg.sv */
/*
 * Constants for the DRAM access timing control block: register map,
 * field layout, reset value and access sequencer states.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package dac_pkg;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [7:0]  DAC_OFS_CTL   = 8'h00;   // Byte address of the access control word
  localparam logic [15:0] DAC_CTL_RESET = 16'h0000;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int DAC_B_IDLE  = 15;
  localparam int DAC_B_PRE   = 12;  // Two bits, 13:12
  localparam int DAC_B_WCLD  = 11;
  localparam int DAC_B_RCD   = 8;   // Two bits, 9:8
  localparam int DAC_B_CKSP  = 3;
  localparam int DAC_B_RDX   = 0;   // Two bits, 1:0

  // ***************************************************
  // Sequencer states
  // ***************************************************
  typedef enum logic [7:0] {
    DAC_S_IDLE = 8'h01,
    DAC_S_RAS  = 8'h02,
    DAC_S_RCD  = 8'h04,
    DAC_S_CLAT = 8'h08,
    DAC_S_CAS  = 8'h10,
    DAC_S_SUSP = 8'h20,
    DAC_S_PRE  = 8'h40,
    DAC_S_INS  = 8'h80
  } dac_state_t;

endpackage : dac_pkg

/* pkg/dac_cfg_if.sv */
/*
 * Carrier between the register file and the field decoder.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface dac_cfg_if;
  logic [15:0] ctl;         // Raw access control word
  logic        idle_en;     // Idle insertion after access
  logic [2:0]  pre_states;  // Precharge states, 1..4
  logic        wcl_dis;     // Drop latency state in write bursts
  logic [2:0]  rcd_waits;   // RAS-to-CAS waits, 0..3
  logic        cksp_en;     // Clock suspend enable
  logic [2:0]  rdx_states;  // Read extension states, 1..4

  modport src (output ctl, input idle_en, pre_states, wcl_dis, rcd_waits, cksp_en, rdx_states);
  modport dec (input ctl, output idle_en, pre_states, wcl_dis, rcd_waits, cksp_en, rdx_states);
endinterface : dac_cfg_if

/* hdl/dac_field_dec.sv */
/*
 * Field decoder: turns the access control word into state counts.
 * Assumes the word is stable and registered upstream.
 */
`timescale 1ns/100ps
module dac_field_dec
  import dac_pkg::*;
(
  // Configuration carrier
  dac_cfg_if.dec cfg
);

  // ***************************************************
  // Two-bit code plus one
  // ***************************************************
  function automatic logic [2:0] dac_plus1(input logic [1:0] code);
    dac_plus1 = {1'b0, code} + 3'h1;
  endfunction : dac_plus1

  // Field extraction
  always_comb begin
    cfg.idle_en    = cfg.ctl[DAC_B_IDLE];
    cfg.pre_states = dac_plus1(cfg.ctl[DAC_B_PRE +: 2]);
    cfg.wcl_dis    = cfg.ctl[DAC_B_WCLD];
    cfg.rcd_waits  = {1'b0, cfg.ctl[DAC_B_RCD +: 2]};
    cfg.cksp_en    = cfg.ctl[DAC_B_CKSP];
    cfg.rdx_states = dac_plus1(cfg.ctl[DAC_B_RDX +: 2]);
  end

endmodule : dac_field_dec

/* dv/dac_mem_model.sv */
/*
 * Far-side memory model: measures the length of each access phase.
 * Assumes phase levels and the request on the one bus clock.
 */
`timescale 1ns/100ps
module dac_mem_model (
  // Clock and access start
  input  wire logic        clk,
  input  wire logic        start,
  // Phase levels, row strobe first
  input  wire logic [6:0]  ph,
  // Four-bit cycle count per phase
  output logic      [27:0] len
);
  // ***************************************************
  // Phase counters
  // ***************************************************
  // Cleared when a request is taken, one count per phase cycle
  always_ff @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (start)
        len[i*4 +: 4] <= 4'h0;
      else if (ph[i])
        len[i*4 +: 4] <= len[i*4 +: 4] + 4'h1;
    end
  end
endmodule : dac_mem_model

/* dv/dram_access_timing_control_tb_top.sv */
/*
 * Self-checking bench: control register over Avalon-MM and phase lengths.
 * Assumes one 25 MHz clock and the control word at byte address 0.
 */
`timescale 1ns/100ps
module dram_access_timing_control_tb_top
  import dac_pkg::*;
;
  // ***************************************************
  // Signals
  // ***************************************************
  logic        clk;
  logic        sys_rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        acc_req;
  logic        acc_ready;
  logic        acc_done;
  logic [7:0]  attr;
  logic [2:0]  idle_len;
  logic [6:0]  ph;
  logic [27:0] len;
  logic [31:0] rd;
  logic [15:0] cfg;
  int          fails;
  int          samples_checked;
  int          cycles;

  // Design and phase watcher
  dac_top #(.AW(4)) dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acc_req(acc_req), .acc_ready(acc_ready),
    .acc_sdram(attr[7]), .acc_write(attr[6]), .acc_dma_single(attr[5]),
    .acc_refresh(attr[4]), .acc_back_to_back(attr[3]), .acc_next_normal(attr[2]),
    .clat_state_en(attr[1]), .idle_cond_met(attr[0]), .idle_len_states(idle_len),
    .ph_ras(ph[6]), .ph_rcd_wait(ph[5]), .ph_clat(ph[4]), .ph_cas(ph[3]),
    .ph_suspend(ph[2]), .ph_precharge(ph[1]), .ph_idle_ins(ph[0]), .acc_done(acc_done));
  dac_mem_model mem (.clk(clk), .start(acc_req & acc_ready), .ph(ph), .len(len));

  // ***************************************************
  // Clock and timeout
  // ***************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ***************************************************
  // Tasks and expectations
  // ***************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be);
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Phase counts packed row strobe first
  function automatic logic [27:0] exp_len(input logic [15:0] c, input logic [7:0] a, input logic [2:0] il);
    logic [3:0] clat;
    logic [3:0] susp;
    logic [3:0] ins;
    logic [3:0] pre;
    clat = {3'h0, a[7] & a[1] & ~(a[6] & a[3] & c[DAC_B_WCLD])};
    susp = (a[7] & ~a[6] & a[5] & c[DAC_B_CKSP]) ? {2'h0, c[1:0]} + 4'h1 : 4'h0;
    ins = (c[DAC_B_IDLE] & a[2] & a[0]) ? {1'h0, il} : 4'h0;
    pre = {2'h0, c[13:12]} + 4'h1;
    if (a[4])
      return {20'h00000, pre, 4'h0};
    return {4'h1, 2'h0, c[9:8], clat, 4'h1, susp, pre, ins};
  endfunction : exp_len

  // One access, then the measured phases against the expected ones
  task automatic acc(input logic [7:0] a, input logic [2:0] il);
    int n;
    @(posedge clk);
    attr <= a;
    idle_len <= il;
    acc_req <= 1'b1;
    @(posedge clk);
    acc_req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (acc_done !== 1'b1 && n < 40);
    chk({3'h0, acc_done, len}, {4'h1, exp_len(cfg, a, il)}, "phase lengths");
  endtask : acc

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    acc_req = 1'b0;
    attr = 8'h00;
    idle_len = 3'h0;
    cfg = DAC_CTL_RESET;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(32'h57F2));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset value, reset timing, unmapped place
    bus(1'b0, DAC_OFS_CTL[3:0], 32'h0, 4'hF);
    chk(rd, {16'h0, DAC_CTL_RESET}, "reset value");
    acc(8'hA7, 3'h5);
    bus(1'b1, 4'h4, 32'hFFFF, 4'hF);
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
    // Upper byte lane alone
    bus(1'b1, DAC_OFS_CTL[3:0], 32'hFFFF_BB0B, 4'h2);
    bus(1'b0, DAC_OFS_CTL[3:0], 32'h0, 4'hF);
    chk(rd, 32'h0000_BB00, "upper lane write");
    $display("test byte lanes done");
    // Corner accesses first, then random settings and attributes
    for (int i = 0; i < 60; i++) begin
      cfg = (i < 2) ? 16'hBB0B : 16'($urandom) & 16'hBB0B;
      bus(1'b1, DAC_OFS_CTL[3:0], {16'h0, cfg}, 4'h3);
      bus(1'b0, DAC_OFS_CTL[3:0], 32'h0, 4'hF);
      chk(rd, {16'h0, cfg}, "control readback");
      if (i == 0)
        acc(8'hCF, 3'h7);
      else if (i == 1)
        acc(8'hA7, 3'h3);
      else
        acc(8'($urandom), 3'($urandom));
    end
    $display("test phase timing done");
    // Mid-run reset clears the fields again
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    cfg = DAC_CTL_RESET;
    bus(1'b0, DAC_OFS_CTL[3:0], 32'h0, 4'hF);
    chk(rd, {16'h0, DAC_CTL_RESET}, "reset value again");
    acc(8'hCF, 3'h7);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : dram_access_timing_control_tb_top
